// ===== core/ser_bank.sv
// status and error register bank with summary, interrupt and read port
`timescale 1ns/1ps

module ser_bank
    import ser_pkg::*;
#(
    parameter int NUM_CH  = 4,
    parameter int NUM_EXP = 8
) (
    input  wire logic               clk_in,
    input  wire logic               reset_in,
    input  wire logic               ce_in,
    // register port
    input  wire logic [23:0]        addr_in,
    input  wire logic [31:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [31:0]        rdata_out,
    output logic                    irq_out,
    // condition inputs, asynchronous levels
    input  wire logic               input_err_in,
    input  wire logic [3:0]         cfg_fault_in,
    input  wire logic [NUM_CH-1:0]  chan_err_in,
    input  wire logic [NUM_EXP-1:0] exp_comm_err_in,
    input  wire logic [NUM_CH-1:0]  io_err_in,
    input  wire logic               low_io_err_in,
    input  wire logic               io_alarm_in,
    input  wire logic               low_io_alarm_in,
    input  wire logic               io_notify_in,
    input  wire logic               mem_nvm_err_in,
    input  wire logic               mem_cal_err_in,
    input  wire logic               mem_setting_err_in,
    input  wire logic               mem_reg_data_err_in,
    input  wire logic               mem_model_err_in,
    input  wire logic               mem_mismatch_in
);

    localparam int SW = 15 + 2 * NUM_CH + NUM_EXP;

    // word select: an area code pair and an offset
    function automatic logic ser_hit(
        input logic [23:0] a,
        input logic        dev,
        input logic [15:0] off
    );
        logic [7:0] area;
        logic       area_ok;
        area = a[23:16];
        if (dev) begin
            area_ok = (area == SER_AREA_DEV) || (area == SER_AREA_DEV_ALT);
        end else begin
            area_ok = (area == SER_AREA_UNIT) ||
                      (area == SER_AREA_UNIT_ALT);
        end
        return area_ok && (a[15:0] == off);
    endfunction : ser_hit

    logic [SW-1:0]      raw_vec;
    logic [SW-1:0]      sync_vec;

    logic               input_err_s;
    logic [3:0]         cfg_fault_s;
    logic [NUM_CH-1:0]  chan_err_s;
    logic [NUM_EXP-1:0] exp_comm_err_s;
    logic [NUM_CH-1:0]  io_err_s;
    logic               low_io_err_s;
    logic               io_alarm_s;
    logic               low_io_alarm_s;
    logic               io_notify_s;
    logic [5:0]         mem_s;

    logic [31:0]        unit_word;
    logic [15:0]        summary_word;
    logic [15:0]        mem_word;
    logic [15:0]        comm_word;

    logic [15:0]        summary_q;
    logic [15:0]        int_status_q;
    logic [15:0]        int_status_d;
    logic [15:0]        int_mask_q;
    logic [15:0]        event_set;
    logic [15:0]        int_clear;
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;

    // every pin condition is synchronised before use
    assign raw_vec = {
        input_err_in,
        cfg_fault_in,
        chan_err_in,
        exp_comm_err_in,
        io_err_in,
        low_io_err_in,
        io_alarm_in,
        low_io_alarm_in,
        io_notify_in,
        mem_nvm_err_in,
        mem_cal_err_in,
        mem_setting_err_in,
        mem_reg_data_err_in,
        mem_model_err_in,
        mem_mismatch_in
    };

    ser_sync #(
        .WIDTH    (SW)
    ) u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .async_in (raw_vec),
        .sync_out (sync_vec)
    );

    assign {
        input_err_s,
        cfg_fault_s,
        chan_err_s,
        exp_comm_err_s,
        io_err_s,
        low_io_err_s,
        io_alarm_s,
        low_io_alarm_s,
        io_notify_s,
        mem_s
    } = sync_vec;

    // unit status word: one live bit, write enable tied to 1, the rest read 0
    always_comb begin
        unit_word                        = 32'h0000_0000;
        unit_word[SER_UNIT_INPUT_ERR_BIT] = input_err_s;
        unit_word[SER_UNIT_WRITE_EN_BIT]  = 1'b1;
    end

    // memory error word
    always_comb begin
        mem_word                       = 16'h0000;
        mem_word[SER_MEM_NVM_BIT]      = mem_s[5];
        mem_word[SER_MEM_CAL_BIT]      = mem_s[4];
        mem_word[SER_MEM_SETTING_BIT]  = mem_s[3];
        mem_word[SER_MEM_REG_DATA_BIT] = mem_s[2];
        mem_word[SER_MEM_MODEL_BIT]    = mem_s[1];
        mem_word[SER_MEM_MISMATCH_BIT] = mem_s[0];
    end

    // communications error word, one bit per expansion unit
    always_comb begin
        comm_word                = 16'h0000;
        comm_word[NUM_EXP-1:0]   = exp_comm_err_s;
    end

    // summary bits are plain ORs of their detail flags, no latching
    always_comb begin
        summary_word = 16'h0000;
        summary_word[SER_SUM_DEVICE_BIT]    = |mem_word;
        summary_word[SER_SUM_CONFIG_BIT]    = |cfg_fault_s;
        summary_word[SER_SUM_CHANNEL_BIT]   = |chan_err_s;
        summary_word[SER_SUM_EXP_COMM_BIT]  = |comm_word;
        summary_word[SER_SUM_IO_ERR_BIT]    = |io_err_s;
        summary_word[SER_SUM_LOW_ERR_BIT]   = low_io_err_s;
        summary_word[SER_SUM_IO_ALARM_BIT]  = io_alarm_s;
        summary_word[SER_SUM_LOW_ALARM_BIT] = low_io_alarm_s;
        summary_word[SER_SUM_IO_NOTIFY_BIT] = io_notify_s;
    end

    // previous summary, kept only to find rising conditions
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            summary_q <= SER_SUMMARY_RST;
        end else if (ce_in) begin
            summary_q <= summary_word;
        end
    end

    // a condition that starts raises its sticky bit
    assign event_set = summary_word & ~summary_q;

    // write-one-to-clear, only for a write to the status word
    always_comb begin
        int_clear = 16'h0000;
        if (wr_in && ser_hit(addr_in, 1'b1, SER_OFF_INT_STATUS)) begin
            int_clear = wdata_in[15:0];
        end
    end

    // set beats clear so an event in the clearing cycle survives
    assign int_status_d = (int_status_q & ~int_clear) | event_set;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            int_status_q <= SER_INT_STATUS_RST;
        end else if (ce_in) begin
            int_status_q <= int_status_d;
        end
    end

    // mask: unused bits may be set but never meet a status bit
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            int_mask_q <= SER_INT_MASK_RST;
        end else if (ce_in) begin
            if (wr_in && ser_hit(addr_in, 1'b1, SER_OFF_INT_MASK)) begin
                int_mask_q <= wdata_in[15:0];
            end
        end
    end

    // level output, built from register bits only
    assign irq_out = |(int_status_q & int_mask_q);

    // read mux; the status words except interrupt status ignore writes entirely
    always_comb begin
        rdata_d = SER_RDATA_RST;
        if (rd_in) begin
            if (ser_hit(addr_in, 1'b0, SER_OFF_UNIT_STATUS)) begin
                rdata_d = unit_word;
            end else if (ser_hit(addr_in, 1'b1, SER_OFF_DEV_SUMMARY)) begin
                rdata_d = {16'h0000, summary_word};
            end else if (ser_hit(addr_in, 1'b1, SER_OFF_MEM_ERR)) begin
                rdata_d = {16'h0000, mem_word};
            end else if (ser_hit(addr_in, 1'b1, SER_OFF_COMM_ERR)) begin
                rdata_d = {16'h0000, comm_word};
            end else if (ser_hit(addr_in, 1'b1, SER_OFF_INT_STATUS)) begin
                rdata_d = {16'h0000, int_status_q};
            end else if (ser_hit(addr_in, 1'b1, SER_OFF_INT_MASK)) begin
                rdata_d = {16'h0000, int_mask_q};
            end
        end
    end

    // data stand one cycle after the strobe, zero at other times
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= SER_RDATA_RST;
        end else if (ce_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;

endmodule : ser_bank

// ===== core/ser_pkg.sv
// shared constants of the status and error register bank
package ser_pkg;

    // area codes; each area answers under two codes
    localparam logic [7:0]  SER_AREA_UNIT      = 8'hC0;
    localparam logic [7:0]  SER_AREA_UNIT_ALT  = 8'h80;
    localparam logic [7:0]  SER_AREA_DEV       = 8'hC4;
    localparam logic [7:0]  SER_AREA_DEV_ALT   = 8'h84;

    // word offsets inside an area
    localparam logic [15:0] SER_OFF_DEV_SUMMARY = 16'h0000;
    localparam logic [15:0] SER_OFF_UNIT_STATUS = 16'h0001;
    localparam logic [15:0] SER_OFF_MEM_ERR     = 16'h0003;
    localparam logic [15:0] SER_OFF_COMM_ERR    = 16'h0004;
    localparam logic [15:0] SER_OFF_INT_STATUS  = 16'h00F0;
    localparam logic [15:0] SER_OFF_INT_MASK    = 16'h00F1;

    // unit status word fields
    localparam int SER_UNIT_INPUT_ERR_BIT = 6;
    localparam int SER_UNIT_WRITE_EN_BIT  = 25;

    // device summary status fields
    localparam int SER_SUM_DEVICE_BIT    = 0;
    localparam int SER_SUM_CONFIG_BIT    = 1;
    localparam int SER_SUM_CHANNEL_BIT   = 2;
    localparam int SER_SUM_EXP_COMM_BIT  = 4;
    localparam int SER_SUM_IO_ERR_BIT    = 10;
    localparam int SER_SUM_LOW_ERR_BIT   = 11;
    localparam int SER_SUM_IO_ALARM_BIT  = 12;
    localparam int SER_SUM_LOW_ALARM_BIT = 13;
    localparam int SER_SUM_IO_NOTIFY_BIT = 14;

    // device memory error fields
    localparam int SER_MEM_NVM_BIT      = 4;
    localparam int SER_MEM_CAL_BIT      = 5;
    localparam int SER_MEM_SETTING_BIT  = 6;
    localparam int SER_MEM_REG_DATA_BIT = 8;
    localparam int SER_MEM_MODEL_BIT    = 9;
    localparam int SER_MEM_MISMATCH_BIT = 12;

    // reset values
    localparam logic [15:0] SER_INT_STATUS_RST = 16'h0000;
    localparam logic [15:0] SER_INT_MASK_RST   = 16'h0000;
    localparam logic [15:0] SER_SUMMARY_RST    = 16'h0000;
    localparam logic [31:0] SER_RDATA_RST      = 32'h0000_0000;

    // timing: flip-flops in each input synchroniser
    localparam int SER_SYNC_STAGES = 2;

endpackage : ser_pkg

// ===== core/ser_sync.sv
// multi-bit two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps

module ser_sync
    import ser_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_q [SER_SYNC_STAGES];

    // first stage feeds only the next stage
    genvar g;
    generate
        for (g = 0; g < SER_SYNC_STAGES; g++) begin : g_stage
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in) begin
                    stage_q[g] <= '0;
                end else if (ce_in) begin
                    if (g == 0) begin
                        stage_q[g] <= async_in;
                    end else begin
                        stage_q[g] <= stage_q[(g == 0) ? 0 : g - 1];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = stage_q[SER_SYNC_STAGES-1];

endmodule : ser_sync

// ===== tb/ser_bank_assertions.sv
// concurrent checks on the status bank read port
`timescale 1ns/1ps
module ser_bank_assertions
    import ser_pkg::*;
#(
    parameter int NUM_CH  = 4,
    parameter int NUM_EXP = 8
) (
    input wire logic               clk_in,
    input wire logic               reset_in,
    input wire logic               ce_in,
    input wire logic [23:0]        addr_in,
    input wire logic               rd_in,
    input wire logic [31:0]        rdata_out,
    input wire logic               input_err_in,
    input wire logic [NUM_EXP-1:0] exp_comm_err_in,
    input wire logic               io_alarm_in,
    input wire logic               mem_nvm_err_in,
    input wire logic               mem_cal_err_in,
    input wire logic               mem_setting_err_in,
    input wire logic               mem_reg_data_err_in,
    input wire logic               mem_model_err_in,
    input wire logic               mem_mismatch_in
);
    wire logic [15:0] mem_w = {3'h0, mem_mismatch_in, 2'h0,
        mem_model_err_in, mem_reg_data_err_in, 1'h0, mem_setting_err_in,
        mem_cal_err_in, mem_nvm_err_in, 4'h0};
    wire logic [7:0]  dev_a = SER_AREA_DEV;
    wire logic rd_unit = rd_in && addr_in == {SER_AREA_UNIT, 16'h0001};
    wire logic rd_sum  = rd_in && addr_in == {dev_a, SER_OFF_DEV_SUMMARY};
    wire logic rd_mem  = rd_in && addr_in == {dev_a, SER_OFF_MEM_ERR};
    wire logic rd_comm = rd_in && addr_in == {dev_a, SER_OFF_COMM_ERR};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in || !ce_in);
    // synchroniser plus read data register: four steady edges are enough
    sequence s_steady(v);
        $stable(v)[*4];
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    a_unit_fixed: assert property (rd_unit |=>
        rdata_out[31:7] == 25'h0040000 && rdata_out[5:0] == 6'h00)
        else $error("unit word fixed bits wrong");
    a_unit_err: assert property (s_steady(input_err_in) ##0 rd_unit
        |=> rdata_out[6] == $past(input_err_in))
        else $error("unit input error bit wrong");
    a_mem_word: assert property (s_steady(mem_w) ##0 rd_mem
        |=> rdata_out == {16'h0, $past(mem_w)})
        else $error("memory error word wrong");
    a_comm_word: assert property (s_steady(exp_comm_err_in) ##0 rd_comm
        |=> rdata_out == 32'($past(exp_comm_err_in)))
        else $error("comm error word wrong");
    a_sum_mem: assert property (s_steady(mem_w) ##0 rd_sum
        |=> rdata_out[0] == |$past(mem_w))
        else $error("summary memory bit wrong");
    a_sum_comm: assert property (s_steady(exp_comm_err_in) ##0 rd_sum
        |=> rdata_out[4] == |$past(exp_comm_err_in))
        else $error("summary comm bit wrong");
    a_sum_alarm: assert property (s_steady(io_alarm_in) ##0 rd_sum
        |=> rdata_out[12] == $past(io_alarm_in))
        else $error("summary alarm bit wrong");
endmodule : ser_bank_assertions

bind ser_bank ser_bank_assertions #(.NUM_CH(NUM_CH), .NUM_EXP(NUM_EXP))
    u_chk (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .input_err_in(input_err_in), .exp_comm_err_in(exp_comm_err_in),
    .io_alarm_in(io_alarm_in), .mem_nvm_err_in(mem_nvm_err_in),
    .mem_cal_err_in(mem_cal_err_in), .mem_setting_err_in(mem_setting_err_in),
    .mem_reg_data_err_in(mem_reg_data_err_in),
    .mem_model_err_in(mem_model_err_in), .mem_mismatch_in(mem_mismatch_in));

// ===== tb/ser_bank_bench.sv
// self-checking bench for the status and error register bank
`timescale 1ns/1ps
module ser_bank_bench
    import ser_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [30:0] cond = '0;
    logic [23:0] addr;
    logic [31:0] wdata, rdata, got;
    logic        wr, rd, irq;
    logic        ce = 1'b1;
    int          n_fail = 0;
    int          check_count = 0;
    localparam logic [23:0] STS = {SER_AREA_DEV, SER_OFF_INT_STATUS};
    localparam logic [23:0] MSK = {SER_AREA_DEV, SER_OFF_INT_MASK};
    always #12.5 clk_in = ~clk_in;
    ser_bank u_ser_bank (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .irq_out(irq), .input_err_in(cond[0]),
        .cfg_fault_in(cond[4:1]), .chan_err_in(cond[8:5]),
        .exp_comm_err_in(cond[16:9]), .io_err_in(cond[20:17]),
        .low_io_err_in(cond[21]), .io_alarm_in(cond[22]),
        .low_io_alarm_in(cond[23]), .io_notify_in(cond[24]),
        .mem_nvm_err_in(cond[25]), .mem_cal_err_in(cond[26]),
        .mem_setting_err_in(cond[27]), .mem_reg_data_err_in(cond[28]),
        .mem_model_err_in(cond[29]), .mem_mismatch_in(cond[30]));
    ser_host u_ser_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    function automatic logic [31:0] exp_sum(input logic [30:0] c);
        return {17'h0, c[24], c[23], c[22], c[21], |c[20:17], 5'h0,
            |c[16:9], 1'b0, |c[8:5], |c[4:1], |c[30:25]};
    endfunction : exp_sum
    function automatic logic [31:0] exp_mem(input logic [30:0] c);
        return {19'h0, c[30], 2'h0, c[29], c[28], 1'h0, c[27:25], 4'h0};
    endfunction : exp_mem
    task automatic check_words(input logic alt);
        logic [7:0] ua, da;
        ua = alt ? SER_AREA_UNIT_ALT : SER_AREA_UNIT;
        da = alt ? SER_AREA_DEV_ALT : SER_AREA_DEV;
        repeat (5) @(posedge clk_in);
        u_ser_host.rd_word({da, SER_OFF_DEV_SUMMARY}, got);
        chk(got, exp_sum(cond));
        u_ser_host.rd_word({ua, SER_OFF_UNIT_STATUS}, got);
        chk(got, {6'h0, 1'b1, 18'h0, cond[0], 6'h0});
        u_ser_host.rd_word({da, SER_OFF_MEM_ERR}, got);
        chk(got, exp_mem(cond));
        u_ser_host.rd_word({da, SER_OFF_COMM_ERR}, got);
        chk(got, {24'h0, cond[16:9]});
    endtask : check_words
    initial begin
        void'($urandom(89));
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        check_words(1'b0);
        cond <= '1;
        check_words(1'b1);
        // one condition at a time isolates every summary term
        for (int i = 0; i < 31; i++) begin
            cond <= 31'h1 << i;
            check_words(i[0]);
        end
        for (int i = 0; i < 40; i++) begin
            cond <= 31'(i[1] ? $urandom : $urandom & $urandom);
            check_words(i[0]);
        end
        // writes to read-only words must leave them untouched
        for (int i = 0; i < 5; i++) begin
            u_ser_host.wr_word({SER_AREA_DEV, 16'(i)}, 32'hFFFF_FFFF);
        end
        u_ser_host.wr_word({SER_AREA_UNIT, 16'h0001}, 32'hFFFF_FFFF);
        check_words(1'b0);
        u_ser_host.rd_word(24'h55_0001, got);
        chk(got, 32'h0);
        cond <= '0;
        repeat (6) @(posedge clk_in);
        u_ser_host.wr_word(STS, 32'h0000_FFFF);
        u_ser_host.wr_word(MSK, 32'h0000_FFFF);
        @(negedge clk_in);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk_in);
        cond[22] <= 1'b1;
        repeat (6) @(negedge clk_in);
        chk({31'h0, irq}, 32'h1);
        u_ser_host.rd_word(STS, got);
        chk(got, 32'h0000_1000);
        u_ser_host.wr_word(MSK, 32'h0);
        @(negedge clk_in);
        chk({31'h0, irq}, 32'h0);
        u_ser_host.wr_word(MSK, 32'h0000_1000);
        @(negedge clk_in);
        chk({31'h0, irq}, 32'h1);
        // clearing while the alarm persists: no new event, so irq drops
        u_ser_host.wr_word(STS, 32'h0000_1000);
        @(negedge clk_in);
        chk({31'h0, irq}, 32'h0);
        // a write while the enable is low is not taken; the mask stays
        @(posedge clk_in);
        ce <= 1'b0;
        u_ser_host.wr_word(MSK, 32'h0);
        ce <= 1'b1;
        u_ser_host.rd_word(MSK, got);
        chk(got, 32'h0000_1000);
        final_report();
    end
    initial begin
        #125000;
        n_fail++;
        final_report();
    end
endmodule : ser_bank_bench

// ===== tb/ser_host.sv
// host model issuing register reads and writes
`timescale 1ns/1ps
module ser_host (
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    output logic      [23:0] addr_out = 24'h000000,
    output logic      [31:0] wdata_out = 32'h0,
    output logic             wr_out = 1'b0,
    output logic             rd_out = 1'b0
);
    task automatic wr_word(input logic [23:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        // released bus carries no stale value
        wdata_out <= ~d;
    endtask : wr_word
    task automatic rd_word(input logic [23:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd_word
endmodule : ser_host
